/* File: logic/mpu_mem_consts.svh */
// Constants for the processor memory address decoder.
// Assumes inclusion by the decoder module only.
`ifndef MPU_MEM_CONSTS_SVH
`define MPU_MEM_CONSTS_SVH

// ----------------------------------------------------------------
// Special function register addresses
// ----------------------------------------------------------------
`define SFR_PTR_A_LOW     8'h82
`define SFR_PTR_A_HIGH    8'h83
`define SFR_PTR_B_LOW     8'h84
`define SFR_PTR_B_HIGH    8'h85
`define SFR_PTR_SELECT    8'h92
`define SFR_FLASH_BANK    8'hb6
`define SFR_PAGE_HIGH     8'hbf
`define SFR_STATUS_WORD   8'hd0

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PTR_SEL_BIT       0
`define PSW_BANK_LO       3
`define PSW_BANK_HI       4
`define RESET_BYTE        8'h00

// ----------------------------------------------------------------
// External data map
// ----------------------------------------------------------------
`define SHARED_EXTERNAL_RAM_LAST         16'h0fff
`define CFG_FIRST         16'h2000
`define CFG_LAST          16'h20ff
`define BATT_FIRST        16'h20c0
`define BATT_LAST         16'h20c7

// ----------------------------------------------------------------
// Internal data map and code space
// ----------------------------------------------------------------
`define IRAM_UPPER        8'h80
`define BITAREA_FIRST     8'h20
`define BITAREA_LAST      8'h2f
`define CODE_BANK_EDGE    16'h7fff
`define FLASH_SMALL_LAST  18'h1ffff
`define FLASH_LARGE_LAST  18'h3ffff

`endif

/* File: logic/mpu_mem_pkg.sv */
// Types shared by the processor memory address decoder.
// Assumes the constants header sits beside it.
package mpu_mem_pkg;
    // Kind of external data access
    typedef enum logic [0:0] {
        XMV_INDEX   = 1'b0,
        XMV_POINTER = 1'b1
    } xmove_kind_t;

    // Decoded external data target
    typedef enum logic [1:0] {
        XT_NONE   = 2'b00,
        XT_SHARED = 2'b01,
        XT_CONFIG = 2'b10,
        XT_BATT   = 2'b11
    } xtarget_t;

    // Pointer update operation from the core
    typedef enum logic [1:0] {
        PTR_NOP  = 2'b00,
        PTR_INC  = 2'b01,
        PTR_LOAD = 2'b10
    } ptr_op_t;

    // External access request
    typedef struct packed {
        logic        valid;
        logic        write;
        xmove_kind_t kind;
        logic [7:0]  indexVal;
    } xreq_t;

    // External access decode result
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        xtarget_t    target;
    } xdec_t;

    // Internal data access request
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       indirect;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ireq_t;
endpackage : mpu_mem_pkg

/* File: logic/mpu_memory_address_decode.sv */
// Address decode and pointer selection for the processor memory system.
// Assumes a core on the same clock drives requests for one cycle each.
`timescale 1ns/1ps
`include "mpu_mem_consts.svh"

module mpu_memory_address_decode #(
    parameter bit LARGE_FLASH = 1'b0
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               reset_n,
    // External data access from the core
    input  wire mpu_mem_pkg::xreq_t xReq,
    output      mpu_mem_pkg::xdec_t xDec_ff,
    // Pointer update from the core
    input  wire mpu_mem_pkg::ptr_op_t ptrOp,
    input  wire logic [15:0]        ptrLoadVal,
    // Internal data access from the core
    input  wire mpu_mem_pkg::ireq_t iReq,
    output      logic [7:0]         iRdata_ff,
    output      logic               sfrHit_ff,
    output      logic               sfrBitable_ff,
    output      logic               ramBitable_ff,
    output      logic [7:0]         bankBase_ff,
    // Code fetch address
    input  wire logic [15:0]        codeAddr,
    output      logic [17:0]        flashAddr_ff
);
    import mpu_mem_pkg::*;

    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    logic [7:0]  ptrLow_ff   [2];
    logic [7:0]  ptrHigh_ff  [2];
    logic        ptrSel_ff;
    logic [7:0]  pageHigh_ff;
    logic [7:0]  psw_ff;
    logic [2:0]  flashBank_ff;
    logic [7:0]  iram_ff     [256];

    // ------------------------------------------------------------
    // Pointer and page decode
    // ------------------------------------------------------------
    logic [15:0] activePtr;
    logic [15:0] incPtr;
    logic [15:0] xAddr;
    logic        inShared;
    logic        inConfig;
    logic        inBatt;
    xtarget_t    xTarget;

    assign activePtr = {ptrHigh_ff[ptrSel_ff], ptrLow_ff[ptrSel_ff]};
    assign incPtr    = activePtr + 16'h0001;
    // One decode serves pointer and paged forms alike
    // Page register over index byte; full pointer
    assign xAddr = (xReq.kind == XMV_POINTER) ? activePtr
                                              : {pageHigh_ff, xReq.indexVal};
    assign inShared = (xAddr <= `SHARED_EXTERNAL_RAM_LAST);
    assign inConfig = (xAddr >= `CFG_FIRST) && (xAddr <= `CFG_LAST);
    assign inBatt   = (xAddr >= `BATT_FIRST) && (xAddr <= `BATT_LAST);
    // Anything else decodes to no target
    assign xTarget = inShared ? XT_SHARED :
                     inBatt   ? XT_BATT   :
                     inConfig ? XT_CONFIG : XT_NONE;

    // Same page path for reads and writes; strobe
    // dropped when nothing is mapped so no memory sees the write
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            xDec_ff <= '0;
        end else begin
            xDec_ff.valid  <= xReq.valid && (xTarget != XT_NONE);
            xDec_ff.write  <= xReq.write && (xTarget != XT_NONE);
            xDec_ff.addr   <= xAddr;
            xDec_ff.target <= xTarget;
        end
    end

    // ------------------------------------------------------------
    // Internal address decode
    // ------------------------------------------------------------
    logic       upperHalf;
    logic       sfrSel;
    logic       sfrKnown;
    logic       sfrWr;
    logic       ramWr;
    logic [7:0] sfrRd;
    logic [7:0] nxt_bankBase;

    assign upperHalf = iReq.addr >= `IRAM_UPPER;
    // Only direct access reaches function registers
    assign sfrSel = upperHalf && !iReq.indirect;
    // Indirect upper and any lower go to RAM
    assign ramWr  = iReq.valid && iReq.write && !sfrSel;
    assign sfrWr  = iReq.valid && iReq.write && sfrSel;
    // Bank base from status word bits
    assign nxt_bankBase = {3'b000, psw_ff[`PSW_BANK_HI:`PSW_BANK_LO],
                           3'b000};

    // Unknown addresses read zero, a harmless undefined value
    always_comb begin
        sfrKnown = 1'b1;
        unique case (iReq.addr)
            `SFR_PTR_A_LOW:   sfrRd = ptrLow_ff[0];
            `SFR_PTR_A_HIGH:  sfrRd = ptrHigh_ff[0];
            `SFR_PTR_B_LOW:   sfrRd = ptrLow_ff[1];
            `SFR_PTR_B_HIGH:  sfrRd = ptrHigh_ff[1];
            `SFR_PTR_SELECT:  sfrRd = {7'h00, ptrSel_ff};
            `SFR_FLASH_BANK:  sfrRd = {5'h00, flashBank_ff};
            `SFR_PAGE_HIGH:   sfrRd = pageHigh_ff;
            `SFR_STATUS_WORD: sfrRd = psw_ff;
            default: begin
                sfrRd    = `RESET_BYTE;
                sfrKnown = 1'b0;
            end
        endcase
    end

    // Read data and address class flags
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            iRdata_ff     <= `RESET_BYTE;
            sfrHit_ff     <= 1'b0;
            sfrBitable_ff <= 1'b0;
            ramBitable_ff <= 1'b0;
            bankBase_ff   <= `RESET_BYTE;
        end else begin
            // One byte address covers all 256 bytes
            iRdata_ff     <= sfrSel ? sfrRd : iram_ff[iReq.addr];
            sfrHit_ff     <= iReq.valid && sfrSel && sfrKnown;
            sfrBitable_ff <= sfrSel && (iReq.addr[2:0] == 3'b000);
            ramBitable_ff <= (iReq.addr >= `BITAREA_FIRST) &&
                             (iReq.addr <= `BITAREA_LAST);
            bankBase_ff   <= nxt_bankBase;
        end
    end

    // RAM storage kept in flip-flops; no reset keeps it compact
    always_ff @(posedge ref_clk) begin
        if (ramWr) begin
            iram_ff[iReq.addr] <= iReq.wdata;
        end
    end

    // ------------------------------------------------------------
    // Pointer registers
    // ------------------------------------------------------------
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_ptr
            logic wrLow;
            logic wrHigh;
            logic useMe;
            assign wrLow  = sfrWr && (iReq.addr == (gp ? `SFR_PTR_B_LOW
                                                       : `SFR_PTR_A_LOW));
            assign wrHigh = sfrWr && (iReq.addr == (gp ? `SFR_PTR_B_HIGH
                                                       : `SFR_PTR_A_HIGH));
            assign useMe  = (ptrSel_ff == 1'(gp));
            // Increment and load hit only the selected pointer
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    ptrLow_ff[gp]  <= `RESET_BYTE;
                    ptrHigh_ff[gp] <= `RESET_BYTE;
                end else if (useMe && ptrOp == PTR_LOAD) begin
                    ptrLow_ff[gp]  <= ptrLoadVal[7:0];
                    ptrHigh_ff[gp] <= ptrLoadVal[15:8];
                end else if (useMe && ptrOp == PTR_INC) begin
                    ptrLow_ff[gp]  <= incPtr[7:0];
                    ptrHigh_ff[gp] <= incPtr[15:8];
                end else begin
                    if (wrLow)  ptrLow_ff[gp]  <= iReq.wdata;
                    if (wrHigh) ptrHigh_ff[gp] <= iReq.wdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Other function registers
    // ------------------------------------------------------------
    // Writes to unknown addresses fall through untouched
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptrSel_ff    <= 1'b0;
            pageHigh_ff  <= `RESET_BYTE;
            psw_ff       <= `RESET_BYTE;
            flashBank_ff <= 3'b000;
        end else if (sfrWr) begin
            if (iReq.addr == `SFR_PTR_SELECT)
                ptrSel_ff <= iReq.wdata[`PTR_SEL_BIT];
            if (iReq.addr == `SFR_PAGE_HIGH)
                pageHigh_ff <= iReq.wdata;
            if (iReq.addr == `SFR_STATUS_WORD)
                psw_ff <= iReq.wdata;
            if (iReq.addr == `SFR_FLASH_BANK)
                flashBank_ff <= iReq.wdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Code space banking
    // ------------------------------------------------------------
    logic [17:0] nxt_flashAddr;
    logic [17:0] flashLimit;

    assign flashLimit = LARGE_FLASH ? `FLASH_LARGE_LAST
                                    : `FLASH_SMALL_LAST;
    // Upper half of code space slides by bank number
    // Address wraps inside the fitted flash size
    assign nxt_flashAddr = (codeAddr > `CODE_BANK_EDGE)
        ? ({flashBank_ff, codeAddr[14:0]} & flashLimit)
        : {3'b000, codeAddr[14:0]};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flashAddr_ff <= 18'h00000;
        end else begin
            flashAddr_ff <= nxt_flashAddr;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_index_page_addr: assert property (
        xReq.valid && xReq.kind == XMV_INDEX |=>
        xDec_ff.addr == {$past(pageHigh_ff), $past(xReq.indexVal)})
        else $error("paged address wrong");
    a_pointer_addr: assert property (
        xReq.valid && xReq.kind == XMV_POINTER |=>
        xDec_ff.addr == $past(activePtr))
        else $error("pointer address wrong");
    a_unmapped_drop: assert property (
        xDec_ff.target == XT_NONE |-> !xDec_ff.write && !xDec_ff.valid)
        else $error("unmapped access passed");
    a_batt_slice: assert property (
        xDec_ff.valid && xDec_ff.addr[15:3] == 13'h0418 |->
        xDec_ff.target == XT_BATT)
        else $error("battery slice missed");
    a_select_keeps: assert property (
        sfrWr && iReq.addr == `SFR_PTR_SELECT && ptrOp == PTR_NOP |=>
        ptrLow_ff[0] == $past(ptrLow_ff[0]) &&
        ptrLow_ff[1] == $past(ptrLow_ff[1]) &&
        ptrHigh_ff[0] == $past(ptrHigh_ff[0]) &&
        ptrHigh_ff[1] == $past(ptrHigh_ff[1]))
        else $error("select changed pointer");
    a_inc_selected: assert property (
        ptrOp == PTR_INC && !sfrWr |=>
        {ptrHigh_ff[ptrSel_ff], ptrLow_ff[ptrSel_ff]} ==
        $past(activePtr) + 16'h0001)
        else $error("increment missed");
    a_indirect_ram: assert property (
        iReq.valid && iReq.indirect && upperHalf |=> !sfrHit_ff)
        else $error("indirect reached register");
    a_bank_base: assert property (
        ##1 bankBase_ff == {3'b000, $past(psw_ff[4:3]), 3'b000})
        else $error("bank base wrong");
    a_code_bank: assert property (
        codeAddr > `CODE_BANK_EDGE |=>
        flashAddr_ff[14:0] == $past(codeAddr[14:0]))
        else $error("code bank offset wrong");
    a_code_bank_sel: assert property (
        codeAddr > `CODE_BANK_EDGE |=>
        flashAddr_ff[17:15] == ($past(flashBank_ff) & flashLimit[17:15]))
        else $error("code bank number wrong");
    a_low_code_flat: assert property (
        codeAddr <= `CODE_BANK_EDGE |=>
        flashAddr_ff == {3'b000, $past(codeAddr[14:0])})
        else $error("low code address moved");
    a_select_pick: assert property (
        xReq.valid && xReq.kind == XMV_POINTER && ptrSel_ff |=>
        xDec_ff.addr == {$past(ptrHigh_ff[1]), $past(ptrLow_ff[1])})
        else $error("secondary pointer not used");

    c_paged_write: cover property (xDec_ff.valid && xDec_ff.write &&
                                   xDec_ff.target == XT_CONFIG);
    c_second_ptr:  cover property (ptrSel_ff && ptrOp == PTR_INC);
    c_sfr_read:    cover property (sfrHit_ff);
endmodule : mpu_memory_address_decode

/* File: testbench/external_data_space_space_model.sv */
// External data space seen by the core: counts decoded strobes.
// Assumes the decoder output is registered on ref_clk.
`timescale 1ns/1ps
module external_data_space_space_model (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               reset_n,
    // Decoded access from the decoder
    input  wire mpu_mem_pkg::xdec_t xDec,
    // Observation for the bench
    output      int                 mappedCnt,
    output      logic               noneSeen
);
    import mpu_mem_pkg::*;
    // Flag a strobe onto no storage
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mappedCnt <= 0;
            noneSeen  <= 1'b0;
        end else if (xDec.valid === 1'b1) begin
            mappedCnt <= mappedCnt + 1;
            // A strobe with no target would corrupt nothing, but is a bug
            if (xDec.target === XT_NONE) noneSeen <= 1'b1;
        end
    end
endmodule : external_data_space_space_model

/* File: testbench/testbench.sv */
// Self-checking bench for the processor memory address decoder.
// Assumes the large flash option and the data space model beside it.
`timescale 1ns/1ps
module testbench;
    import mpu_mem_pkg::*;
    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    xreq_t       xReq = '0;
    xdec_t       xDec_ff;
    ptr_op_t     ptrOp = PTR_NOP;
    logic [15:0] ptrLoadVal = 16'h0000;
    ireq_t       iReq = '0;
    logic [7:0]  iRdata_ff;
    logic [7:0]  bankBase_ff;
    logic        sfrHit_ff;
    logic        sfrBitable_ff;
    logic        ramBitable_ff;
    logic [15:0] codeAddr = 16'h0000;
    logic [17:0] flashAddr_ff;
    logic        noneSeen;
    int          mappedCnt;
    int          expMapped = 0;
    int          errorCnt = 0;
    int          comparisons = 0;
    int          seed = 32'he994b427;
    logic [15:0] a;
    logic [15:0] v;
    logic [7:0]  bk;
    logic [7:0]  regs [7] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h92,
                              8'hbf, 8'hd0};
    logic [15:0] xc [12] = '{16'h0000, 16'h0fff, 16'h1000, 16'h1fff,
        16'h2000, 16'h20bf, 16'h20c0, 16'h20c7, 16'h20c8, 16'h20ff,
        16'h2100, 16'hffff};

    mpu_memory_address_decode #(.LARGE_FLASH(1'b1)) uut (
        .ref_clk(ref_clk), .reset_n(reset_n), .xReq(xReq),
        .xDec_ff(xDec_ff), .ptrOp(ptrOp), .ptrLoadVal(ptrLoadVal),
        .iReq(iReq), .iRdata_ff(iRdata_ff), .sfrHit_ff(sfrHit_ff),
        .sfrBitable_ff(sfrBitable_ff), .ramBitable_ff(ramBitable_ff),
        .bankBase_ff(bankBase_ff), .codeAddr(codeAddr),
        .flashAddr_ff(flashAddr_ff));
    external_data_space_space_model model (.ref_clk(ref_clk), .reset_n(reset_n),
        .xDec(xDec_ff), .mappedCnt(mappedCnt), .noneSeen(noneSeen));

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Guard against a stuck run
    initial begin
        #500000;
        errorCnt++;
        reportAndStop();
    end
    function automatic xtarget_t tgt(input logic [15:0] ad);
        if (ad <= 16'h0fff) return XT_SHARED;
        if (ad >= 16'h20c0 && ad <= 16'h20c7) return XT_BATT;
        if (ad >= 16'h2000 && ad <= 16'h20ff) return XT_CONFIG;
        return XT_NONE;
    endfunction : tgt
    // Read-back view of a register: the select keeps only its bit 0
    function automatic logic [7:0] regView(input logic [7:0] ad,
                                           input logic [7:0] wd);
        return (ad == 8'h92) ? {7'h00, wd[0]} : wd;
    endfunction : regView
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One internal access; outputs stand after the taking edge
    task automatic iacc(input logic w, input logic ind,
                        input logic [7:0] ad, input logic [7:0] wd);
        @(posedge ref_clk);
        iReq <= '{1'b1, w, ind, ad, wd};
        @(posedge ref_clk);
        iReq.valid <= 1'b0;
        #1;
    endtask : iacc
    task automatic xacc(input xmove_kind_t k, input logic [7:0] ix,
                        input logic [15:0] ea);
        logic m;
        logic wr;
        m  = (tgt(ea) != XT_NONE);
        wr = 1'($random(seed));
        @(posedge ref_clk);
        xReq <= '{1'b1, wr, k, ix};
        @(posedge ref_clk);
        xReq.valid <= 1'b0;
        #1;
        expMapped += m;
        chk(xDec_ff.valid, m);
        chk(xDec_ff.write, wr & m);
        chk(xDec_ff.target, tgt(ea));
        chk(xDec_ff.addr, ea);
    endtask : xacc
    task automatic pop(input ptr_op_t op, input logic [15:0] lv);
        @(posedge ref_clk);
        ptrOp      <= op;
        ptrLoadVal <= lv;
        @(posedge ref_clk);
        ptrOp <= PTR_NOP;
    endtask : pop
    task automatic reportAndStop();
        $display("Errors %0d comparisons %0d", errorCnt, comparisons);
        if (errorCnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : reportAndStop

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        // Reset values, then random write and read back
        foreach (regs[i]) begin
            iacc(1'b0, 1'b0, regs[i], 8'h00);
            chk(iRdata_ff, 8'h00);
            v = 16'($random(seed));
            iacc(1'b1, 1'b0, regs[i], v[7:0]);
            iacc(1'b0, 1'b0, regs[i], 8'h00);
            chk(iRdata_ff, regView(regs[i], v[7:0]));
            chk(sfrHit_ff, 1'b1);
        end
        // Unimplemented register swallows writes and reads zero
        iacc(1'b1, 1'b0, 8'h86, 8'ha5);
        iacc(1'b0, 1'b0, 8'h86, 8'h00);
        chk(iRdata_ff, 8'h00);
        chk(sfrHit_ff, 1'b0);
        iacc(1'b1, 1'b0, 8'h92, 8'h00);
        // Paged moves over map edges and random addresses
        for (int i = 0; i < 52; i++) begin
            a = (i < 12) ? xc[i] : 16'($random(seed));
            iacc(1'b1, 1'b0, 8'hbf, a[15:8]);
            xacc(XMV_INDEX, a[7:0], a);
        end
        // Two pointers: select, load, increment with wrap
        v = 16'($random(seed));
        iacc(1'b1, 1'b0, 8'h82, v[7:0]);
        iacc(1'b1, 1'b0, 8'h83, v[15:8]);
        xacc(XMV_POINTER, 8'h00, v);
        iacc(1'b1, 1'b0, 8'h92, 8'h01);
        pop(PTR_LOAD, 16'hffff);
        pop(PTR_INC, 16'h0000);
        xacc(XMV_POINTER, 8'h00, 16'h0000);
        iacc(1'b1, 1'b0, 8'h92, 8'h00);
        xacc(XMV_POINTER, 8'h00, v);
        pop(PTR_INC, 16'h0000);
        xacc(XMV_POINTER, 8'h00, v + 16'h0001);
        iacc(1'b0, 1'b0, 8'h84, 8'h00);
        chk(iRdata_ff, 8'h00);
        iacc(1'b0, 1'b0, 8'h85, 8'h00);
        chk(iRdata_ff, 8'h00);
        // Upper half splits by mode, lower half shared
        iacc(1'b1, 1'b1, 8'hd0, 8'h5a);
        iacc(1'b1, 1'b0, 8'h45, 8'h3c);
        iacc(1'b0, 1'b1, 8'hd0, 8'h00);
        chk(iRdata_ff, 8'h5a);
        iacc(1'b0, 1'b1, 8'h45, 8'h00);
        chk(iRdata_ff, 8'h3c);
        // Bank select through the status word
        for (int i = 0; i < 4; i++) begin
            iacc(1'b1, 1'b0, 8'hd0, 8'(i << 3));
            iacc(1'b0, 1'b0, 8'hd0, 8'h00);
            chk(iRdata_ff, 8'(i << 3));
            chk(bankBase_ff, 8'(i * 8));
        end
        // Bit addressable areas
        for (int i = 0; i < 40; i++) begin
            bk = (i < 8) ? 8'h1f + 8'(i % 2) * 8'h01 + 8'(i / 2) * 8'h10
                         : 8'($random(seed));
            iacc(1'b0, 1'b0, bk, 8'h00);
            chk(ramBitable_ff, bk >= 8'h20 && bk <= 8'h2f);
            chk(sfrBitable_ff, bk[7] && bk[2:0] == 3'h0);
        end
        // Code fetches through the flash bank
        bk = 8'($random(seed)) & 8'h07;
        iacc(1'b1, 1'b0, 8'hb6, bk);
        for (int i = 0; i < 24; i++) begin
            a = (i < 4) ? xc[11] & 16'(32'h7fff8000 >> (8 * i)) :
                16'($random(seed));
            @(posedge ref_clk);
            codeAddr <= a;
            @(posedge ref_clk);
            #1;
            chk(flashAddr_ff, (a <= 16'h7fff) ? {2'b00, a} :
                {bk[2:0], a[14:0]});
        end
        // Top bank and top offset reach the last byte of large flash
        iacc(1'b1, 1'b0, 8'hb6, 8'h07);
        @(posedge ref_clk);
        codeAddr <= 16'hffff;
        @(posedge ref_clk);
        #1;
        chk(flashAddr_ff, 18'h3ffff);
        chk(noneSeen, 1'b0);
        chk(mappedCnt, expMapped);
        // Reset in mid-run returns page and first pointer low byte to zero
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        iacc(1'b0, 1'b0, 8'hbf, 8'h00);
        chk(iRdata_ff, 8'h00);
        iacc(1'b0, 1'b0, 8'h82, 8'h00);
        chk(iRdata_ff, 8'h00);
        reportAndStop();
    end
endmodule : testbench
